// [bench/ar_pin_partner.sv]
// pin partner: drives the timer input pin and times the pwm waveform it receives
// assumes one clock domain shared with the timer; the bench commands the pin
`timescale 1ns/1ps
module ar_pin_partner (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        clk_run,
   input  wire logic        drive_level,
   input  wire logic        timer_output_pin,
   output logic             timer_input_pin,
   output logic [15:0]      period_len,
   output logic [15:0]      high_len
);
   logic        half_ff;
   logic        pwm_d_ff;
   logic [15:0] run_ff;

   // external clock of period four cycles, only while clk_run is set, else a plain level
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         half_ff         <= 1'b0;
         timer_input_pin <= 1'b0;
      end else if (clk_run) begin
         half_ff         <= ~half_ff;
         timer_input_pin <= half_ff ? ~timer_input_pin : timer_input_pin;
      end else begin
         timer_input_pin <= drive_level;
      end
   end

   // period measured rise to rise, high time rise to fall
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwm_d_ff   <= 1'b0;
         run_ff     <= 16'h0000;
         period_len <= 16'h0000;
         high_len   <= 16'h0000;
      end else begin
         pwm_d_ff <= timer_output_pin;
         run_ff   <= (timer_output_pin && !pwm_d_ff) ? 16'h0001 : run_ff + 16'h0001;
         if (timer_output_pin && !pwm_d_ff) begin
            period_len <= run_ff;
         end
         if (!timer_output_pin && pwm_d_ff) begin
            high_len <= run_ff;
         end
      end
   end
endmodule : ar_pin_partner

// [bench/ar_timer_test.sv]
// bench for the timer: apb register tasks, pin partner makes edges and times the pwm
// assumes zero-wait apb answers whose read data stands at the completing edge
`timescale 1ns/1ps
module ar_timer_test;
   import ar_timer_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        timer_input_pin;
   logic        timer_output_pin;
   logic        irq_req;
   logic        clk_run = 1'b0;
   logic        drive_level = 1'b0;
   logic [15:0] period_len;
   logic [15:0] high_len;
   logic        last_err;
   logic [7:0]  rd_v;
   int          hi_seen;
   int          err_count = 0;
   int          n_checks = 0;

   always #10 core_clk = ~core_clk;

   ar_timer ar_timer_i (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_input_pin(timer_input_pin), .timer_output_pin(timer_output_pin),
      .irq_req(irq_req));
   ar_pin_partner ar_pin_partner_i (.core_clk(core_clk), .rst_b(rst_b), .clk_run(clk_run),
      .drive_level(drive_level), .timer_output_pin(timer_output_pin),
      .timer_input_pin(timer_input_pin), .period_len(period_len), .high_len(high_len));

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask : chk

   // one apb transfer; request held until pready is sampled high, bounded wait
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      penable <= 1'b0;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_count++;
         final_report;
      end
      rd       = prdata[7:0];
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, rd_v);
   endtask : wr

   task automatic rdc(input string name, input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00, rd_v);
      chk(name, {8'h00, exp}, {8'h00, rd_v});
   endtask : rdc

   task automatic waitc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : waitc

   // stop before touching the source or divider, then reload f0, compare f8, load and run
   task automatic start(input logic [7:0] se, input logic [7:0] mb);
      wr(IDX_MODE_CONTROL, 8'h00);
      wr(IDX_SOURCE_EDGE, se);
      wr(IDX_RELOAD_CAPT, 8'hf0);
      wr(IDX_COMPARE, 8'hf8);
      wr(IDX_MODE_CONTROL, 8'hc0 | mb);
   endtask : start

   // sixteen counts per period, eight of them high, each count lasting ratio cycles
   task automatic pwm_chk(input string name, input int ratio);
      waitc(3 * 16 * ratio + 8);
      chk({name, " period"}, 16'(16 * ratio), period_len);
      chk({name, " high"}, 16'(8 * ratio), high_len);
   endtask : pwm_chk

   task automatic pin(input logic v);
      drive_level <= v;
      waitc(4);
   endtask : pin

   initial begin
      hi_seen = 0;
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      rdc("mode after reset", IDX_MODE_CONTROL, 8'h00);
      apb(1'b0, 8'hd8, 8'h00, rd_v);
      chk("unmapped error", 16'h0001, {15'h0000, last_err});
      start(8'h00, 8'h00);
      for (int i = 0; i < 40; i++) begin
         @(posedge core_clk);
         if (timer_output_pin !== 1'b0) hi_seen++;
      end
      chk("output disabled", 16'h0000, 16'(hi_seen));
      start(8'h00, 8'h24);
      rdc("mode readback", IDX_MODE_CONTROL, 8'h64);
      pwm_chk("auto reload", 1);
      chk("irq overflow", 16'h0001, {15'h0000, irq_req});
      wr(IDX_MODE_CONTROL, 8'h24);
      apb(1'b0, IDX_LOAD_VALUE, 8'h00, rd_v);
      waitc(20);
      rdc("frozen counter", IDX_LOAD_VALUE, rd_v);
      rdc("flags set", IDX_STATUS_FLAGS, 8'h03);
      wr(IDX_STATUS_FLAGS, 8'h06);
      rdc("overflow cleared", IDX_STATUS_FLAGS, 8'h02);
      chk("irq compare masked", 16'h0000, {15'h0000, irq_req});
      wr(IDX_STATUS_FLAGS, 8'h00);
      rdc("flags cleared", IDX_STATUS_FLAGS, 8'h00);
      for (int k = 0; k < 8; k++) begin
         start({k[2:0], 5'h00}, 8'h20);
         pwm_chk("divider", 1 << k);
      end
      start(8'h01, 8'h20);
      pwm_chk("divide by three", 3);
      clk_run <= 1'b1;
      start(8'h02, 8'h20);
      pwm_chk("pin clock", 4);
      clk_run <= 1'b0;
      // counter kept stopped so captured and loaded values are known exactly
      wr(IDX_MODE_CONTROL, 8'h00);
      wr(IDX_SOURCE_EDGE, 8'h04);
      wr(IDX_STATUS_FLAGS, 8'h00);
      wr(IDX_LOAD_VALUE, 8'h77);
      rdc("load write", IDX_LOAD_VALUE, 8'h77);
      wr(IDX_MODE_CONTROL, 8'h11);
      pin(1'b1);
      rdc("capture", IDX_RELOAD_CAPT, 8'h77);
      rdc("edge flag", IDX_STATUS_FLAGS, 8'h04);
      chk("irq edge", 16'h0001, {15'h0000, irq_req});
      pin(1'b0);
      wr(IDX_MODE_CONTROL, 8'h12);
      wr(IDX_LOAD_VALUE, 8'h42);
      pin(1'b1);
      rdc("capture with reset", IDX_RELOAD_CAPT, 8'h42);
      rdc("counter reset", IDX_LOAD_VALUE, 8'h00);
      pin(1'b0);
      wr(IDX_MODE_CONTROL, 8'h13);
      wr(IDX_RELOAD_CAPT, 8'h3c);
      pin(1'b1);
      rdc("external load", IDX_LOAD_VALUE, 8'h3c);
      pin(1'b0);
      wr(IDX_MODE_CONTROL, 8'h01);
      wr(IDX_SOURCE_EDGE, 8'h0c);
      wr(IDX_STATUS_FLAGS, 8'h00);
      pin(1'b1);
      rdc("rising ignored", IDX_STATUS_FLAGS, 8'h00);
      pin(1'b0);
      rdc("falling seen", IDX_STATUS_FLAGS, 8'h04);
      chk("irq edge masked", 16'h0000, {15'h0000, irq_req});
      wr(IDX_SOURCE_EDGE, 8'h08);
      wr(IDX_STATUS_FLAGS, 8'h00);
      pin(1'b1);
      pin(1'b0);
      rdc("detect off", IDX_STATUS_FLAGS, 8'h00);
      // reserved source gives no ticks, so counter and prescaler stay put
      wr(IDX_MODE_CONTROL, 8'h00);
      wr(IDX_SOURCE_EDGE, 8'h03);
      wr(IDX_LOAD_VALUE, 8'h10);
      wr(IDX_MODE_CONTROL, 8'h40);
      waitc(10);
      rdc("reserved source", IDX_LOAD_VALUE, 8'h10);
      rdc("prescaler held", IDX_PRESCALER, 8'h00);
      final_report;
   end
endmodule : ar_timer_test

// [design/ar_timer.sv]
// auto-reload pwm / capture 8-bit timer with 7-bit prescaler, apb register slave
// assumes timer_input_pin is synchronous to core_clk; one clock domain only
// Contract
// - counter increments on each prescaler output tick while counting enabled
// - auto-reload: overflow reloads counter from reload value, output pin goes high
// - any mode: counter equal to compare drives output low, sets compare flag
// - overflow sets sticky overflow flag; request when its enable set
// - compare match sets sticky compare flag; request when its enable set
// - capture: active input edge copies counter, sets edge flag, may request
// - capture-with-reset also clears counter and prescaler on each capture
// - external-load mode: active edge loads reload value, running or not
// - mode bits 1:0 select auto-reload, capture, capture-reset, external load
// - every counter load clears the prescaler in the same cycle
// - load trigger bit 7 loads reload value, clears prescaler, reads zero
// - count enable bit 6 runs timer; clear freezes prescaler and counter
// - output enable bit 5 gates the pwm waveform onto the output pin
// - each irq enable requests only while enable and its flag both set
// - status flags read normally; write zero clears, write one keeps
// - overflow flag set when a count tick finds the counter at all ones
// - writing 06h clears only overflow flag; other pending flags stay latched
// - mode control clears to 00h on reset, timer disabled
// - three-bit divider select gives ratios 1 through 128
// - clock source select: internal, internal divided by three, pin; 11 reserved
// - edge detect enable gates edges; polarity bit picks rising or falling
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module ar_timer
   import ar_timer_pkg::*;
#(
   parameter int CNT_W = 8,
   parameter int PSC_W = 7
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        timer_input_pin,
   output logic             timer_output_pin,
   output logic             irq_req
);
   // the register map and field positions are fixed at eight and seven bits
   initial begin
      if (CNT_W != 8 || PSC_W != 7) $error("ar_timer supports only an 8-bit counter and 7-bit prescaler");
   end

   apb_req_s           req;
   logic [7:0]         mode_control_ff;
   logic [2:0]         status_flags_ff;
   source_edge_s       source_edge_config_ff;
   logic [7:0]         reload_capture_value_ff;
   logic [7:0]         compare_value_ff;
   logic [7:0]         counter_value_ff;
   logic [PSC_W-1:0]   prescaler_count_ff;
   logic [1:0]         div3_ff;
   logic               pin_prev_ff;
   logic               pwm_level_ff;
   logic               out_pin_ff;
   logic               wr_en;
   logic               rd_en;
   logic [9:0]         reg_idx;
   logic               addr_hit;
   logic               src_tick;
   logic               psc_tick;
   logic               count_tick;
   logic               active_edge;
   logic               overflow_evt;
   logic               compare_evt;
   logic               capture_evt;
   logic               ext_load_evt;
   logic               sw_load_trig;
   logic               sw_load_reg;
   logic               any_load;
   logic [7:0]         nxt_counter;
   logic [2:0]         keep;
   timer_mode_e        mode;

   assign req     = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
   assign mode    = timer_mode_e'(mode_control_ff[1:0]);
   assign reg_idx = req.paddr[11:ADDR_LSB];

   // zero-wait apb slave: every access completes in its first access cycle
   assign pready   = req.psel & req.penable;
   assign addr_hit = reg_idx[9:8] == 2'h0 &&
                     (reg_idx[7:0] == IDX_MODE_CONTROL || reg_idx[7:0] == IDX_STATUS_FLAGS ||
                      reg_idx[7:0] == IDX_SOURCE_EDGE  || reg_idx[7:0] == IDX_RELOAD_CAPT  ||
                      reg_idx[7:0] == IDX_COMPARE      || reg_idx[7:0] == IDX_LOAD_VALUE   ||
                      reg_idx[7:0] == IDX_PRESCALER);
   assign pslverr  = pready & ~addr_hit;
   assign wr_en    = pready & req.pwrite & addr_hit;
   // read data fetched in setup so it stands when pready is high; it is one cycle old
   assign rd_en    = req.psel & ~req.penable & ~req.pwrite & addr_hit;

   // read mux registered into prdata; load trigger always reads zero
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         unique case (reg_idx[7:0])
            IDX_MODE_CONTROL: prdata <= {24'h00_0000, 1'b0, mode_control_ff[6:0]};
            IDX_STATUS_FLAGS: prdata <= {29'h0000_0000, status_flags_ff};
            IDX_SOURCE_EDGE:  prdata <= {24'h00_0000, source_edge_config_ff};
            IDX_RELOAD_CAPT:  prdata <= {24'h00_0000, reload_capture_value_ff};
            IDX_COMPARE:      prdata <= {24'h00_0000, compare_value_ff};
            IDX_LOAD_VALUE:   prdata <= {24'h00_0000, counter_value_ff};
            IDX_PRESCALER:    prdata <= {25'h000_0000, prescaler_count_ff};
            default:          prdata <= 32'h0000_0000;
         endcase
      end
   end

   // mode control register; load trigger bit is never stored
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_control_ff <= MC_RESET;
      end else if (wr_en && reg_idx[7:0] == IDX_MODE_CONTROL) begin
         mode_control_ff <= req.pwdata[7:0] & MC_WRITE_MASK;
      end
   end

   // clock source / edge / divider configuration; reserved bit kept zero
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         source_edge_config_ff <= source_edge_s'(SE_RESET);
      end else if (wr_en && reg_idx[7:0] == IDX_SOURCE_EDGE) begin
         source_edge_config_ff <= source_edge_s'(req.pwdata[7:0] & SE_WRITE_MASK);
      end
   end

   // compare register
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         compare_value_ff <= 8'h00;
      end else if (wr_en && reg_idx[7:0] == IDX_COMPARE) begin
         compare_value_ff <= req.pwdata[7:0];
      end
   end

   // input edge detect on the synchronous pin
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_prev_ff <= 1'b0;
      end else begin
         pin_prev_ff <= timer_input_pin;
      end
   end

   // polarity 0 rising, 1 falling; nothing when detection is off
   assign active_edge = source_edge_config_ff.edge_detect_on &&
                        (source_edge_config_ff.edge_polarity ? (pin_prev_ff & ~timer_input_pin)
                                                             : (~pin_prev_ff & timer_input_pin));

   // internal clock divided by three, as a one-cycle enable
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         div3_ff <= 2'h0;
      end else begin
         div3_ff <= (div3_ff == DIV3_LAST) ? 2'h0 : div3_ff + 2'h1;
      end
   end

   // source multiplexer; reserved code gives no ticks
   always_comb begin
      unique case (source_edge_config_ff.clock_source)
         SRC_INTERNAL: src_tick = 1'b1;
         SRC_INT_DIV3: src_tick = (div3_ff == DIV3_LAST);
         SRC_PIN:      src_tick = ~pin_prev_ff & timer_input_pin;
         default:      src_tick = 1'b0;
      endcase
   end

   // prescaler tap n ticks when the low n bits wrap to zero (ratio 2^n)
   always_comb begin
      logic [PSC_W:0] mask;
      mask     = (8'h01 << source_edge_config_ff.divider_sel) - 8'h01;
      psc_tick = src_tick && ((prescaler_count_ff & mask[PSC_W-1:0]) == mask[PSC_W-1:0]);
   end

   assign count_tick   = mode_control_ff[MC_COUNT_ENABLE] & psc_tick;
   assign sw_load_trig = wr_en && reg_idx[7:0] == IDX_MODE_CONTROL && req.pwdata[MC_LOAD_TRIGGER];
   assign sw_load_reg  = wr_en && reg_idx[7:0] == IDX_LOAD_VALUE;
   assign capture_evt  = active_edge && (mode == MODE_CAPTURE || mode == MODE_CAPTURE_RST);
   assign ext_load_evt = active_edge && mode == MODE_EXT_LOAD;
   assign overflow_evt = count_tick && counter_value_ff == CNT_ALL_ONES;
   assign any_load     = sw_load_trig | sw_load_reg | ext_load_evt |
                         (capture_evt && mode == MODE_CAPTURE_RST) |
                         (overflow_evt && mode == MODE_AUTO_RELOAD);

   // prescaler: frozen while disabled, cleared by any counter load
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prescaler_count_ff <= '0;
      end else if (any_load) begin
         prescaler_count_ff <= '0;
      end else if (mode_control_ff[MC_COUNT_ENABLE] && src_tick) begin
         prescaler_count_ff <= prescaler_count_ff + 1'b1;
      end
   end

   // counter next value; a core write outranks hardware loads
   always_comb begin
      nxt_counter = counter_value_ff;
      if (sw_load_reg) begin
         nxt_counter = req.pwdata[7:0];
      end else if (sw_load_trig || ext_load_evt) begin
         nxt_counter = reload_capture_value_ff;
      end else if (capture_evt && mode == MODE_CAPTURE_RST) begin
         nxt_counter = 8'h00;
      end else if (overflow_evt && mode == MODE_AUTO_RELOAD) begin
         nxt_counter = reload_capture_value_ff;
      end else if (count_tick) begin
         nxt_counter = counter_value_ff + 8'h01;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         counter_value_ff <= 8'h00;
      end else begin
         counter_value_ff <= nxt_counter;
      end
   end

   // reload/capture register: capture beats a core write in the same cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reload_capture_value_ff <= 8'h00;
      end else if (capture_evt) begin
         reload_capture_value_ff <= counter_value_ff;
      end else if (wr_en && reg_idx[7:0] == IDX_RELOAD_CAPT) begin
         reload_capture_value_ff <= req.pwdata[7:0];
      end
   end

   // compare is checked on the next count, one event per arrival at the value
   assign compare_evt = (nxt_counter != counter_value_ff) && nxt_counter == compare_value_ff;

   // status write keeps only the flags written as one
   assign keep = (wr_en && reg_idx[7:0] == IDX_STATUS_FLAGS) ? req.pwdata[2:0] : 3'h7;

   // status flags: write-zero clears, hardware set wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_flags_ff <= 3'h0;
      end else begin
         status_flags_ff[SF_OVERFLOW] <= overflow_evt | (status_flags_ff[SF_OVERFLOW] & keep[SF_OVERFLOW]);
         status_flags_ff[SF_COMPARE]  <= compare_evt  | (status_flags_ff[SF_COMPARE] & keep[SF_COMPARE]);
         status_flags_ff[SF_EDGE]     <= active_edge  | (status_flags_ff[SF_EDGE] & keep[SF_EDGE]);
      end
   end

   // pwm level: overflow sets, compare match clears (clear wins if both)
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwm_level_ff <= 1'b0;
      end else if (compare_evt) begin
         pwm_level_ff <= 1'b0;
      end else if (overflow_evt) begin
         pwm_level_ff <= 1'b1;
      end
   end

   // output pin registered so that it is glitch free; low while disabled
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_pin_ff <= 1'b0;
      end else begin
         out_pin_ff <= mode_control_ff[MC_OUTPUT_ENABLE] & pwm_level_ff;
      end
   end
   assign timer_output_pin = out_pin_ff;

   // one level request for all three sources
   assign irq_req = (mode_control_ff[MC_EDGE_IRQ_EN] & status_flags_ff[SF_EDGE]) |
                    (mode_control_ff[MC_COMPARE_IRQ_EN] & status_flags_ff[SF_COMPARE]) |
                    (mode_control_ff[MC_OVERFLOW_IRQ_EN] & status_flags_ff[SF_OVERFLOW]);

   // assertions
   // one clock domain; properties from chk_cnt_step on take clock and reset from here
   default clocking assert_cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   chk_ovf_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
      overflow_evt |=> status_flags_ff[SF_OVERFLOW])
      else $error("overflow did not set overflow flag");
   chk_cmp_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
      compare_evt |=> status_flags_ff[SF_COMPARE] && !pwm_level_ff)
      else $error("compare did not set flag or clear pwm level");
   chk_reload_value: assert property (@(posedge core_clk) disable iff (!rst_b)
      (overflow_evt && mode == MODE_AUTO_RELOAD && !sw_load_reg && !sw_load_trig && !ext_load_evt)
      |=> counter_value_ff == $past(reload_capture_value_ff))
      else $error("auto-reload did not load reload value");
   chk_freeze_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
      (!mode_control_ff[MC_COUNT_ENABLE] && !any_load) |=> $stable(prescaler_count_ff))
      else $error("prescaler moved while disabled");
   chk_load_clr_psc: assert property (@(posedge core_clk) disable iff (!rst_b)
      any_load |=> prescaler_count_ff == '0)
      else $error("counter load did not clear prescaler");
   chk_capture_copy: assert property (@(posedge core_clk) disable iff (!rst_b)
      capture_evt |=> reload_capture_value_ff == $past(counter_value_ff) && status_flags_ff[SF_EDGE])
      else $error("capture did not copy counter");
   chk_trig_reads_0: assert property (@(posedge core_clk) disable iff (!rst_b)
      (rd_en && reg_idx[7:0] == IDX_MODE_CONTROL) |=> !prdata[MC_LOAD_TRIGGER])
      else $error("load trigger read back as one");
   chk_irq_follows: assert property (@(posedge core_clk) disable iff (!rst_b)
      status_flags_ff == 3'h0 |-> !irq_req)
      else $error("request without a flag");
   chk_out_disabled: assert property (@(posedge core_clk) disable iff (!rst_b)
      !mode_control_ff[MC_OUTPUT_ENABLE] |=> !timer_output_pin)
      else $error("output pin high while disabled");
   chk_flag_w1_keep: assert property (@(posedge core_clk) disable iff (!rst_b)
      (wr_en && reg_idx[7:0] == IDX_STATUS_FLAGS && req.pwdata[2:0] == 3'h7) |=>
      (status_flags_ff & $past(status_flags_ff)) == $past(status_flags_ff))
      else $error("writing one cleared a flag");

   // counter steps, holds and loads
   chk_cnt_step: assert property (count_tick && !any_load
      |=> counter_value_ff == $past(counter_value_ff) + 8'h01)
      else $error("counter did not step by one");
   chk_stop_hold: assert property (!mode_control_ff[MC_COUNT_ENABLE] && !any_load
      |=> $stable(counter_value_ff))
      else $error("counter moved while disabled");
   chk_trig_load: assert property (sw_load_trig
      |=> counter_value_ff == $past(reload_capture_value_ff) && prescaler_count_ff == '0)
      else $error("load trigger did not load counter");
   chk_ext_load: assert property (ext_load_evt && !sw_load_reg
      |=> counter_value_ff == $past(reload_capture_value_ff))
      else $error("edge did not load counter");
   chk_capt_rst_clr: assert property (capture_evt && mode == MODE_CAPTURE_RST
      && !sw_load_reg && !sw_load_trig |=> counter_value_ff == 8'h00 && prescaler_count_ff == '0)
      else $error("capture did not clear counter");
   chk_load_reg: assert property (sw_load_reg
      |=> counter_value_ff == $past(req.pwdata[7:0]) && prescaler_count_ff == '0)
      else $error("core load did not land");

   // flags and request
   chk_ovf_clear: assert property (wr_en && reg_idx[7:0] == IDX_STATUS_FLAGS
      && !req.pwdata[SF_OVERFLOW] && !overflow_evt |=> !status_flags_ff[SF_OVERFLOW])
      else $error("zero write kept overflow flag");
   chk_ovf_only_evt: assert property ($rose(status_flags_ff[SF_OVERFLOW])
      |-> $past(overflow_evt))
      else $error("overflow flag without rollover");
   chk_cmp_only_evt: assert property ($rose(status_flags_ff[SF_COMPARE])
      |-> $past(compare_evt))
      else $error("compare flag without match");
   chk_edge_sets_flag: assert property (active_edge
      |=> status_flags_ff[SF_EDGE])
      else $error("edge did not set edge flag");
   chk_irq_ovf_level: assert property (mode_control_ff[MC_OVERFLOW_IRQ_EN] && status_flags_ff[SF_OVERFLOW]
      |-> irq_req)
      else $error("enabled flag without request");

   // pwm level, pin, source and edge gating
   chk_ovf_sets_pwm: assert property (overflow_evt && !compare_evt
      |=> pwm_level_ff)
      else $error("overflow did not raise pwm level");
   chk_out_follows: assert property (mode_control_ff[MC_OUTPUT_ENABLE]
      |=> timer_output_pin == $past(pwm_level_ff))
      else $error("output pin not following pwm");
   chk_rsvd_no_tick: assert property (source_edge_config_ff.clock_source == SRC_RESERVED
      |-> !src_tick)
      else $error("reserved source ticked");
   chk_detect_off: assert property (!source_edge_config_ff.edge_detect_on
      |-> !active_edge)
      else $error("edge seen with detection off");
endmodule : ar_timer

// [design/ar_timer_pkg.sv]
// package for the auto-reload pwm/capture timer: register offsets, fields, reset values, modes
// assumes a 32-bit apb slave with byte addresses equal to the printed offsets times four
package ar_timer_pkg;
   // printed offsets are register indices; byte address is index times four
   localparam logic [7:0]  IDX_MODE_CONTROL  = 8'hd5;
   localparam logic [7:0]  IDX_STATUS_FLAGS  = 8'hd6;
   localparam logic [7:0]  IDX_SOURCE_EDGE   = 8'hd7;
   localparam logic [7:0]  IDX_RELOAD_CAPT   = 8'hd9;
   localparam logic [7:0]  IDX_COMPARE       = 8'hda;
   localparam logic [7:0]  IDX_LOAD_VALUE    = 8'hdb;
   localparam logic [7:0]  IDX_PRESCALER     = 8'hdc;
   localparam int          ADDR_LSB          = 2;
   // mode control fields
   localparam int          MC_LOAD_TRIGGER   = 7;
   localparam int          MC_COUNT_ENABLE   = 6;
   localparam int          MC_OUTPUT_ENABLE  = 5;
   localparam int          MC_EDGE_IRQ_EN    = 4;
   localparam int          MC_COMPARE_IRQ_EN = 3;
   localparam int          MC_OVERFLOW_IRQ_EN = 2;
   localparam logic [7:0]  MC_RESET          = 8'h00;
   localparam logic [7:0]  MC_WRITE_MASK     = 8'h7f;
   // status flag fields
   localparam int          SF_EDGE           = 2;
   localparam int          SF_COMPARE        = 1;
   localparam int          SF_OVERFLOW       = 0;
   localparam logic [7:0]  SE_RESET          = 8'h00;
   localparam logic [7:0]  SE_WRITE_MASK     = 8'hef;
   localparam logic [7:0]  CNT_ALL_ONES      = 8'hff;
   // divide-by-three pre-divider for the internal clock source
   localparam logic [1:0]  DIV3_LAST         = 2'h2;

   typedef enum logic [1:0] {
      MODE_AUTO_RELOAD  = 2'b00,
      MODE_CAPTURE      = 2'b01,
      MODE_CAPTURE_RST  = 2'b10,
      MODE_EXT_LOAD     = 2'b11
   } timer_mode_e;

   typedef enum logic [1:0] {
      SRC_INTERNAL = 2'b00,
      SRC_INT_DIV3 = 2'b01,
      SRC_PIN      = 2'b10,
      SRC_RESERVED = 2'b11
   } clock_source_e;

   // apb request carried as one bundle
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   // source/edge configuration layout
   typedef struct packed {
      logic [2:0]    divider_sel;
      logic          reserved;
      logic          edge_polarity;
      logic          edge_detect_on;
      clock_source_e clock_source;
   } source_edge_s;
endpackage : ar_timer_pkg
